/* File: socket_window_map_control.sv */
// Summary of operation
// - Routing field picks status-change interrupt line
// - Codes 1110 and 1111 select lines 14, 15
// - Memory window enable bits drive mem_window_en_out
// - I/O window enable bits claim I/O ranges
// - Window 0 size bit unless auto-size set
// - Auto-size uses card wide I/O indicator
// - Window 1 size bit 4, auto-size bit 5
// - Timing select bits choose timing set
// - Start low bytes at index 08h and 0Ch
// - Inclusive start-to-end I/O decode
// - Start high and end bytes at 09h-0Bh and 0Dh-0Fh
// - Enabled set status flag raises interrupt
//
`timescale 1ns/1ps
`include "socket_window_consts.svh"
module socket_window_map_control #(
  parameter int NUM_SOCKETS = 2
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7+$clog2(NUM_SOCKETS):0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire socket_window_pkg::io_req_t io_req_in,
  input wire logic [4*NUM_SOCKETS-1:0] status_event_in,
  input wire logic [NUM_SOCKETS-1:0] card_wide_io_indicator_n_in,
  output socket_window_pkg::io_claim_t io_claim_out,
  output logic [`MEM_WINDOWS*NUM_SOCKETS-1:0] mem_window_en_out,
  output logic [15:0] irq_line_out,
  output logic irq_out
);
  import socket_window_pkg::*;

  localparam int SOCK_W = $clog2(NUM_SOCKETS);
  localparam int NWIN = 2 * NUM_SOCKETS;

  if (NUM_SOCKETS < 2 || NUM_SOCKETS > 16) begin : g_bad_sockets
    $error("NUM_SOCKETS must lie between 2 and 16");
  end

  // ----------------------------------------
  // Register access helpers
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input socket_regs_t r, input logic [3:0] st,
                                          input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IDX_STATUS: v = {4'h0, st};
      `IDX_INT_CFG: v = {r.route, r.ev_en};
      `IDX_WIN_EN: v = r.win_en;
      `IDX_IO_CTL: v = r.io_ctl;
      `IDX_IO0_START_LO: v = r.io0_start[7:0];
      `IDX_IO0_START_HI: v = r.io0_start[15:8];
      `IDX_IO0_END_LO: v = r.io0_end[7:0];
      `IDX_IO0_END_HI: v = r.io0_end[15:8];
      `IDX_IO1_START_LO: v = r.io1_start[7:0];
      `IDX_IO1_START_HI: v = r.io1_start[15:8];
      `IDX_IO1_END_LO: v = r.io1_end[7:0];
      `IDX_IO1_END_HI: v = r.io1_end[15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  function automatic socket_regs_t write_reg(input socket_regs_t r, input logic [5:0] idx,
                                             input logic [7:0] wd);
    socket_regs_t n;
    n = r;
    case (idx)
      `IDX_INT_CFG: {n.route, n.ev_en} = wd;
      `IDX_WIN_EN: begin
        n.win_en = wd;
        n.win_en[`WEN_COMPAT] = 1'b0;
      end
      `IDX_IO_CTL: n.io_ctl = wd;
      `IDX_IO0_START_LO: n.io0_start[7:0] = wd;
      `IDX_IO0_START_HI: n.io0_start[15:8] = wd;
      `IDX_IO0_END_LO: n.io0_end[7:0] = wd;
      `IDX_IO0_END_HI: n.io0_end[15:8] = wd;
      `IDX_IO1_START_LO: n.io1_start[7:0] = wd;
      `IDX_IO1_START_HI: n.io1_start[15:8] = wd;
      `IDX_IO1_END_LO: n.io1_end[7:0] = wd;
      `IDX_IO1_END_HI: n.io1_end[15:8] = wd;
      default: n = r;
    endcase
    return n;
  endfunction : write_reg

  // ----------------------------------------
  // Bus slave: one wait cycle per access
  // ----------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  socket_regs_t regs_q [NUM_SOCKETS];
  logic [3:0] status_q [NUM_SOCKETS];

  wire req = avs_read_in || avs_write_in;
  wire accept = req && wait_q;
  wire wr_fire = avs_write_in && !wait_q && avs_byteenable_in[0];
  wire [5:0] idx = avs_address_in[7:2];
  wire [SOCK_W-1:0] sock = avs_address_in[7+SOCK_W:8];
  wire sock_ok = 32'(sock) < NUM_SOCKETS;
  wire [7:0] rd_byte = sock_ok ? read_reg(regs_q[sock], status_q[sock], idx) : 8'h00;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !accept;
      if (accept && avs_read_in) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;

  // ----------------------------------------
  // Per-socket registers and status flags
  // ----------------------------------------
  logic [NUM_SOCKETS-1:0] pend;
  logic [NUM_SOCKETS-1:0] wsync1_q;
  logic [NUM_SOCKETS-1:0] wsync2_q;

  for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
    wire sel = wr_fire && sock_ok && (32'(sock) == s);
    wire [3:0] clr = (sel && idx == `IDX_STATUS) ? avs_writedata_in[3:0] : 4'h0;
    // Set wins over a clear in the same cycle
    wire [3:0] status_d = (status_q[s] & ~clr) | status_event_in[4*s +: 4];
    assign pend[s] = |(status_q[s] & regs_q[s].ev_en);

    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        regs_q[s] <= '0;
        status_q[s] <= 4'h0;
      end else begin
        status_q[s] <= status_d;
        if (sel) begin
          regs_q[s] <= write_reg(regs_q[s], idx, avs_writedata_in[7:0]);
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt routing and window enables
  // ----------------------------------------
  logic [15:0] line_d;
  logic irq_q;
  logic [15:0] irq_line_q;
  logic [`MEM_WINDOWS*NUM_SOCKETS-1:0] mem_en_q;

  always_comb begin
    line_d = 16'h0000;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      if (pend[s]) begin
        line_d = line_d | route_line(regs_q[s].route);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_q <= 1'b0;
      irq_line_q <= 16'h0000;
      mem_en_q <= '0;
      wsync1_q <= '1;
      wsync2_q <= '1;
    end else begin
      irq_q <= |pend;
      irq_line_q <= line_d;
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        mem_en_q[`MEM_WINDOWS*s +: `MEM_WINDOWS] <= regs_q[s].win_en[`MEM_WINDOWS-1:0];
      end
      wsync1_q <= card_wide_io_indicator_n_in;
      wsync2_q <= wsync1_q;
    end
  end

  assign irq_out = irq_q;
  assign irq_line_out = irq_line_q;
  assign mem_window_en_out = mem_en_q;

  // ----------------------------------------
  // I/O window decode, lowest socket and window first
  // ----------------------------------------
  logic [NWIN-1:0] hit_w;
  logic [NWIN-1:0] wide_w;
  logic [NWIN-1:0] tsel_w;

  for (genvar w = 0; w < NWIN; w++) begin : g_win
    localparam int S = w / 2;
    localparam int K = w % 2;
    wire [7:0] ctl = regs_q[S].io_ctl;
    assign tsel_w[w] = ctl[`CTL_TSEL_LSB + `CTL_WIN_STRIDE*K];
    io_window_decode u_dec (
      .enable_in(regs_q[S].win_en[`WEN_IO_LSB + K]),
      .start_in(K == 0 ? regs_q[S].io0_start : regs_q[S].io1_start),
      .end_in(K == 0 ? regs_q[S].io0_end : regs_q[S].io1_end),
      .addr_in(io_req_in.addr),
      .fixed_wide_in(ctl[`CTL_SIZE_LSB + `CTL_WIN_STRIDE*K]),
      .auto_size_in(ctl[`CTL_AUTO_LSB + `CTL_WIN_STRIDE*K]),
      .card_wide_in(~wsync2_q[S]),
      .hit_out(hit_w[w]),
      .wide_out(wide_w[w])
    );
  end

  io_claim_t claim_d;
  io_claim_t claim_q;

  always_comb begin
    claim_d = '0;
    for (int w = NWIN - 1; w >= 0; w--) begin
      if (io_req_in.valid && hit_w[w]) begin
        claim_d.hit = 1'b1;
        claim_d.socket = 4'(w / 2);
        claim_d.window = 1'(w % 2);
        claim_d.wide = wide_w[w];
        claim_d.timing_set = tsel_w[w];
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      claim_q <= '0;
    end else begin
      claim_q <= claim_d;
    end
  end

  assign io_claim_out = claim_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  logic hi_route_any;
  logic io_en_any;
  always_comb begin
    hi_route_any = 1'b0;
    io_en_any = 1'b0;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      hi_route_any = hi_route_any | (regs_q[s].route[3:1] == 3'b111);
      io_en_any = io_en_any | (|regs_q[s].win_en[7:6]);
    end
  end

  sequence s_ev0_armed;
    status_event_in[0] && regs_q[0].ev_en[0] ##1 regs_q[0].ev_en[0];
  endsequence
  sequence s_win_write;
    wr_fire && sock_ok && sock == '0 && idx == `IDX_WIN_EN;
  endsequence

  chk_one_wait: assert property (accept |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("waitrequest not low for exactly one cycle");
  chk_compat_zero: assert property (
    (accept && avs_read_in && idx == `IDX_WIN_EN) |=> !avs_readdata_out[`WEN_COMPAT])
    else $error("compatibility bit read as one");
  chk_event_irq: assert property (s_ev0_armed |=> irq_out)
    else $error("enabled status event gave no interrupt");
  // Lines are ORed across sockets, so only a lone pending socket must give at most one line
  chk_route_legal: assert property (
    $onehot0($past(pend)) |-> $onehot0(irq_line_out))
    else $error("several interrupt lines");
  chk_route_reserved: assert property ((irq_line_out & `RESERVED_LINES) == 16'h0000)
    else $error("reserved interrupt line driven");
  chk_route_high: assert property (
    (irq_line_out[15] || irq_line_out[14]) |-> $past(hi_route_any) && irq_out)
    else $error("line 14 or 15 without its routing code");
  chk_mem_enable: assert property (
    s_win_write |-> ##2 mem_window_en_out[4:0] == $past(avs_writedata_in[4:0], 2))
    else $error("memory window enable not applied");
  chk_io_disabled: assert property ((io_req_in.valid && !io_en_any) |=> !io_claim_out.hit)
    else $error("claim with no I/O window enabled");
  chk_io_range: assert property (
    (io_req_in.valid && regs_q[0].win_en[`WEN_IO_LSB] && io_req_in.addr >= regs_q[0].io0_start
     && io_req_in.addr <= regs_q[0].io0_end) |=> io_claim_out.hit && io_claim_out.socket == 4'h0
     && !io_claim_out.window)
    else $error("in-range access to window 0 not claimed");
  chk_fixed_width: assert property (
    (io_req_in.valid && hit_w[0] && !regs_q[0].io_ctl[`CTL_AUTO_LSB])
    |=> io_claim_out.wide == $past(regs_q[0].io_ctl[`CTL_SIZE_LSB]))
    else $error("fixed width not taken from size bit");
  chk_auto_width: assert property (
    (io_req_in.valid && hit_w[0] && regs_q[0].io_ctl[`CTL_AUTO_LSB])
    |=> io_claim_out.wide == !$past(wsync2_q[0]))
    else $error("auto width not taken from card indicator");
  chk_timing_sel: assert property (
    (io_req_in.valid && hit_w[0])
    |=> io_claim_out.timing_set == $past(regs_q[0].io_ctl[`CTL_TSEL_LSB]))
    else $error("timing set not taken from select bit");
endmodule : socket_window_map_control

/* File: socket_window_consts.svh */
`ifndef SOCKET_WINDOW_CONSTS_SVH
`define SOCKET_WINDOW_CONSTS_SVH
// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define IDX_STATUS 6'h04
`define IDX_INT_CFG 6'h05
`define IDX_WIN_EN 6'h06
`define IDX_IO_CTL 6'h07
`define IDX_IO0_START_LO 6'h08
`define IDX_IO0_START_HI 6'h09
`define IDX_IO0_END_LO 6'h0a
`define IDX_IO0_END_HI 6'h0b
`define IDX_IO1_START_LO 6'h0c
`define IDX_IO1_START_HI 6'h0d
`define IDX_IO1_END_LO 6'h0e
`define IDX_IO1_END_HI 6'h0f
// ----------------------------------------
// Field positions
// ----------------------------------------
`define WEN_COMPAT 5
`define WEN_IO_LSB 6
`define CTL_SIZE_LSB 0
`define CTL_AUTO_LSB 1
`define CTL_TSEL_LSB 3
`define CTL_WIN_STRIDE 4
`define MEM_WINDOWS 5
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define REG_RESET 8'h00
`define ROUTE_OFF 4'h0
`define RESERVED_LINES 16'h2147
`endif

/* File: socket_window_pkg.sv */
package socket_window_pkg;
  // ----------------------------------------
  // Per-socket register image
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] route;
    logic [3:0] ev_en;
    logic [7:0] win_en;
    logic [7:0] io_ctl;
    logic [15:0] io1_end;
    logic [15:0] io1_start;
    logic [15:0] io0_end;
    logic [15:0] io0_start;
  } socket_regs_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } io_req_t;

  typedef struct packed {
    logic hit;
    logic [3:0] socket;
    logic window;
    logic wide;
    logic timing_set;
  } io_claim_t;

  // Valid routing codes name their own line number; reserved give none
  function automatic logic [15:0] route_line(input logic [3:0] code);
    logic [15:0] line;
    line = 16'h0000;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: line[code] = 1'b1;
      default: line = 16'h0000;
    endcase
    return line;
  endfunction : route_line
endpackage : socket_window_pkg

/* File: io_window_decode.sv */
`timescale 1ns/1ps
module io_window_decode (
  input wire logic enable_in,
  input wire logic [15:0] start_in,
  input wire logic [15:0] end_in,
  input wire logic [15:0] addr_in,
  input wire logic fixed_wide_in,
  input wire logic auto_size_in,
  input wire logic card_wide_in,
  output logic hit_out,
  output logic wide_out
);
  wire in_range = (addr_in >= start_in) && (addr_in <= end_in);
  assign hit_out = enable_in && in_range;
  // Card sense overrides the fixed size bit when auto-size is set
  assign wide_out = auto_size_in ? card_wide_in : fixed_wide_in;
endmodule : io_window_decode

/* File: card_model.sv */
`timescale 1ns/1ps
module card_model #(
  parameter int N = 2
) (
  input wire logic [N-1:0] wide_in,
  output logic [N-1:0] ind_n_out
);
  // ----------------------------------------
  // Card width indicator
  // ----------------------------------------
  // Card pulls its indicator low while the addressed port is 16-bit
  assign ind_n_out = ~wide_in;
endmodule : card_model

/* File: test_socket_window_map_control.sv */
`timescale 1ns/1ps
module test_socket_window_map_control;
  import socket_window_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [8:0] addr = 9'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  io_req_t io_req = '0;
  logic [7:0] events = 8'h00;
  logic [1:0] card_wide = 2'h0;
  logic [1:0] ind_n;
  io_claim_t claim;
  logic [9:0] mem_en;
  logic [15:0] irq_line;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h00016431;

  always #5 mclk_in = ~mclk_in;

  socket_window_map_control u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .io_req_in(io_req), .status_event_in(events),
    .card_wide_io_indicator_n_in(ind_n), .io_claim_out(claim), .mem_window_en_out(mem_en),
    .irq_line_out(irq_line), .irq_out(irq));

  card_model #(.N(2)) u_card (.wide_in(card_wide), .ind_n_out(ind_n));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] exp_line(input logic [3:0] c);
    logic [15:0] m;
    m = 16'h0000;
    if (c inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf}) m[c] = 1'b1;
    return m;
  endfunction : exp_line

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic s, input logic [5:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    addr <= {s, i, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h0, d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      num_errors++;
      $display("wrong value at %0t: bus answer timed out", $time);
      final_report();
    end
  endtask : bus

  task automatic lookup(input logic [15:0] a, input logic h, input logic wd, input logic ts,
                        input logic wn);
    io_claim_t e;
    e = '{hit: 1'b1, socket: 4'h0, window: wn, wide: wd, timing_set: ts};
    @(posedge mclk_in);
    io_req <= '{valid: 1'b1, addr: a};
    @(posedge mclk_in);
    io_req <= '0;
    #1;
    if (h) check({24'h0, claim}, {24'h0, e});
    else check({31'h0, claim.hit}, 32'h0);
  endtask : lookup

  task automatic pulse(input logic [7:0] v);
    @(posedge mclk_in);
    events <= v;
    @(posedge mclk_in);
    events <= 8'h00;
  endtask : pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] q;
    logic [7:0] r;
    logic [15:0] st;
    logic [15:0] en;
    logic w;
    logic wd;
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int i = 4; i < 16; i++) begin
      bus(1'b0, 1'b0, i[5:0], 8'h00, q);
      check({24'h0, q}, 32'h0);
    end
    bus(1'b0, 1'b0, 6'h3f, 8'h00, q);
    check({24'h0, q}, 32'h0);
    for (int s = 0; s < 2; s++) begin
      r = 8'(rnd());
      bus(1'b1, s[0], 6'h06, r, q);
      bus(1'b0, s[0], 6'h06, 8'h00, q);
      check({24'h0, q}, {24'h0, r & 8'hdf});
      check({27'h0, mem_en[5*s+:5]}, {27'h0, r[4:0]});
    end
    // Socket 1 windows would otherwise shadow address 0
    bus(1'b1, 1'b1, 6'h06, 8'h00, q);
    $display("test reset and enables done");
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 1'b0, 6'h05, {c[3:0], 4'h1}, q);
      pulse(8'h01);
      repeat (2) @(posedge mclk_in);
      check({31'h0, irq}, 32'h1);
      check({16'h0, irq_line}, {16'h0, exp_line(c[3:0])});
      bus(1'b1, 1'b0, 6'h04, 8'h01, q);
      repeat (2) @(posedge mclk_in);
      check({31'h0, irq}, 32'h0);
    end
    bus(1'b1, 1'b0, 6'h05, 8'h30, q);
    pulse(8'h02);
    repeat (2) @(posedge mclk_in);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, 1'b0, 6'h04, 8'h00, q);
    check({24'h0, q}, 32'h2);
    bus(1'b1, 1'b0, 6'h04, 8'h02, q);
    $display("test interrupt routing done");
    for (int it = 0; it < 12; it++) begin
      w = it[0];
      r = (it < 2) ? 8'h22 : 8'(rnd());
      st = 16'(rnd()) | 16'h0100;
      st = st & 16'hfeff;
      en = st + {8'h00, 8'(rnd())};
      bus(1'b1, 1'b0, 6'h07, r, q);
      bus(1'b1, 1'b0, 6'h06, w ? 8'h80 : 8'h40, q);
      for (int j = 0; j < 4; j++) begin
        bus(1'b1, 1'b0, {3'b001, w, j[1:0]}, 8'({en, st} >> (8 * j)), q);
      end
      card_wide <= 2'(rnd() & 32'h1);
      repeat (4) @(posedge mclk_in);
      wd = r[4*w+1] ? card_wide[0] : r[4*w];
      lookup(st - 16'h1, 1'b0, wd, r[4*w+3], w);
      lookup(st, 1'b1, wd, r[4*w+3], w);
      lookup(en, 1'b1, wd, r[4*w+3], w);
      lookup(en + 16'h1, 1'b0, wd, r[4*w+3], w);
      bus(1'b1, 1'b0, 6'h06, 8'h00, q);
      lookup(st, 1'b0, wd, r[4*w+3], w);
    end
    $display("test io windows done");
    bus(1'b1, 1'b0, 6'h06, 8'h1f, q);
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    bus(1'b0, 1'b0, 6'h07, 8'h00, q);
    check({24'h0, q}, 32'h0);
    check({22'h0, mem_en}, 32'h0);
    check({24'h0, claim}, 32'h0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : test_socket_window_map_control
